// ==== dv/rsf_regs_tb.sv ====
// Self-checking bench for the ramp spread and fault register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rsf_pkg::*;

  logic       sys_clk;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [8:0] det;
  logic       otp_check_fail;
  logic       coef_write_fail;
  logic       ramp_tick;
  logic [1:0] ramp_amplitude_setting;
  logic       ramp_manual;
  int         mismatches;
  int         comparisons;
  int         cycles;
  logic [7:0] fault_addr [9];
  logic [7:0] fault_mask [9];

  // Fault pins packed in one vector so a loop can walk them
  rsf_regs i_dut (
    .sys_clk                (sys_clk),
    .sys_rst                (sys_rst),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_wdata              (reg_wdata),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .reg_rvalid             (reg_rvalid),
    .left_dc_det            (det[0]),
    .right_dc_det           (det[1]),
    .left_oc_det            (det[2]),
    .right_oc_det           (det[3]),
    .clock_fault_det        (det[4]),
    .supply_over_det        (det[5]),
    .supply_under_det       (det[6]),
    .thermal_shutdown_det   (det[7]),
    .thermal_warning_det    (det[8]),
    .otp_check_fail         (otp_check_fail),
    .coef_write_fail        (coef_write_fail),
    .ramp_tick              (ramp_tick),
    .ramp_amplitude_setting (ramp_amplitude_setting),
    .ramp_manual            (ramp_manual)
  );

  // 25 MHz system clock
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Hang guard; the whole sequence needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask : check

  // One-cycle write strobe, launched and dropped on falling edges
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
  endtask : wr

  // Read answers exactly one cycle after the strobe, valid for one cycle
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01, "read valid");
    check(reg_rdata, exp, "read data");
    @(negedge sys_clk);
    check({7'h00, reg_rvalid}, 8'h00, "valid one cycle");
  endtask : rd

  // Cycles between ticks, skipping the first two periods disturbed by reconfiguring
  task automatic measure(input int exp);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (ramp_tick !== 1'b1 && n < 1000);
    end
    comparisons++;
    if (n != exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: tick period %0d expected %0d",
               $time, n, exp);
    end
  endtask : measure

  // Eight periods after settling; all inside lo..hi and not all equal
  task automatic measure_spread(input int lo, input int hi);
    int n;
    int n_min;
    int n_max;
    n_min = 1000;
    n_max = 0;
    for (int k = 0; k < 10; k++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (ramp_tick !== 1'b1 && n < 1000);
      if (k >= 2 && n < n_min) n_min = n;
      if (k >= 2 && n > n_max) n_max = n;
    end
    comparisons++;
    if (n_min < lo || n_max > hi || n_min == n_max) begin
      mismatches++;
      $display("CHECK FAILED at %0t: spread periods %0d to %0d not in %0d to %0d",
               $time, n_min, n_max, lo, hi);
    end
  endtask : measure_spread

  initial begin
    sys_rst         = 1'b1;
    reg_addr        = 8'h00;
    reg_wr          = 1'b0;
    reg_wdata       = 8'h00;
    reg_rd          = 1'b0;
    det             = 9'h000;
    otp_check_fail  = 1'b0;
    coef_write_fail = 1'b0;
    mismatches      = 0;
    comparisons     = 0;
    fault_addr = '{ADDR_CHANNEL_FAULT, ADDR_CHANNEL_FAULT,
                   ADDR_CHANNEL_FAULT, ADDR_CHANNEL_FAULT,
                   ADDR_GLOBAL_FAULT_A, ADDR_GLOBAL_FAULT_A,
                   ADDR_GLOBAL_FAULT_A, ADDR_GLOBAL_FAULT_B,
                   ADDR_THERMAL_WARN};
    fault_mask = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h04, 8'h02, 8'h01, 8'h01,
                   8'h04};
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;

    // Reset values, read-only flags clear, unmapped and clear reg read zero
    rd(ADDR_SPREAD_CONTROL, 8'h00);
    rd(ADDR_SPREAD_RANGE, 8'h00);
    rd(ADDR_RAMP_DIVISOR, 8'h50);
    rd(ADDR_TRIANGLE_STEPS, 8'h11);
    rd(ADDR_TRI_BOUND_AMP, 8'h24);
    for (int a = 0; a < 4; a++) begin
      rd(ADDR_CHANNEL_FAULT + 8'(a), 8'h00);
    end
    rd(ADDR_FAULT_CLEAR, 8'h00);
    rd(8'h00, 8'h00);
    check({7'h00, ramp_manual}, 8'h00, "manual at reset");
    check({6'h00, ramp_amplitude_setting}, 8'h01, "amp at reset");
    measure(80);
    $display("test reset values done");

    // Every bit of the spread registers stores and reads back
    for (int a = 0; a < 5; a++) begin
      wr(ADDR_SPREAD_CONTROL + 8'(a), 8'hA5);
      rd(ADDR_SPREAD_CONTROL + 8'(a), 8'hA5);
      wr(ADDR_SPREAD_CONTROL + 8'(a), 8'h5A);
      rd(ADDR_SPREAD_CONTROL + 8'(a), 8'h5A);
    end
    wr(ADDR_TRIANGLE_STEPS, 8'hF1);
    rd(ADDR_TRIANGLE_STEPS, 8'hF1);
    wr(ADDR_TRIANGLE_STEPS, 8'h1F);
    rd(ADDR_TRIANGLE_STEPS, 8'h1F);
    wr(ADDR_TRI_BOUND_AMP, 8'h1F);
    rd(ADDR_TRI_BOUND_AMP, 8'h1F);
    check({6'h00, ramp_amplitude_setting}, 8'h00, "amp 00");
    wr(ADDR_TRI_BOUND_AMP, 8'h40);
    @(negedge sys_clk);
    check({6'h00, ramp_amplitude_setting}, 8'h02, "amp 10");
    wr(ADDR_TRI_BOUND_AMP, 8'h60);
    @(negedge sys_clk);
    check({6'h00, ramp_amplitude_setting}, 8'h03, "amp 11");
    wr(ADDR_SPREAD_RANGE, 8'h00);
    $display("test register readback done");

    // Manual mode with no spread: period is N, or 2N with halved source
    wr(ADDR_RAMP_DIVISOR, 8'h10);
    wr(ADDR_SPREAD_CONTROL, 8'h10);
    @(negedge sys_clk);
    check({7'h00, ramp_manual}, 8'h01, "manual set");
    measure(16);
    wr(ADDR_SPREAD_CONTROL, 8'h30);
    measure(32);
    // Triangle with limit 1 and unit steps walks N-1 to N+1
    wr(ADDR_TRIANGLE_STEPS, 8'h11);
    wr(ADDR_TRI_BOUND_AMP, 8'h21);
    wr(ADDR_SPREAD_CONTROL, 8'h11);
    measure_spread(15, 17);
    // Random range 2 adds 0 to 3 source ticks
    wr(ADDR_SPREAD_RANGE, 8'h20);
    wr(ADDR_SPREAD_CONTROL, 8'h12);
    measure_spread(16, 19);
    wr(ADDR_SPREAD_RANGE, 8'h00);
    wr(ADDR_SPREAD_CONTROL, 8'h00);
    @(negedge sys_clk);
    check({7'h00, ramp_manual}, 8'h00, "manual clear");
    $display("test ramp period done");

    // Each fault pin: sticky flag, writes ignored, clear needs bit 7
    for (int i = 0; i < 9; i++) begin
      @(negedge sys_clk);
      det[i] = 1'b1;
      repeat (8) @(negedge sys_clk);
      det[i] = 1'b0;
      repeat (8) @(negedge sys_clk);
      rd(fault_addr[i], fault_mask[i]);
      wr(fault_addr[i], 8'hFF);
      rd(fault_addr[i], fault_mask[i]);
      wr(ADDR_FAULT_CLEAR, 8'h7F);
      rd(fault_addr[i], fault_mask[i]);
      wr(ADDR_FAULT_CLEAR, 8'h80);
      rd(fault_addr[i], 8'h00);
    end
    // A pin still active wins over the clear
    @(negedge sys_clk);
    det[0] = 1'b1;
    repeat (8) @(negedge sys_clk);
    wr(ADDR_FAULT_CLEAR, 8'h80);
    rd(ADDR_CHANNEL_FAULT, 8'h08);
    det[0] = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(ADDR_FAULT_CLEAR, 8'h80);
    rd(ADDR_CHANNEL_FAULT, 8'h00);
    $display("test fault pins done");

    // Same-clock events for the OTP check and coefficient write
    @(negedge sys_clk);
    otp_check_fail = 1'b1;
    @(negedge sys_clk);
    otp_check_fail = 1'b0;
    rd(ADDR_GLOBAL_FAULT_A, 8'h80);
    @(negedge sys_clk);
    coef_write_fail = 1'b1;
    @(negedge sys_clk);
    coef_write_fail = 1'b0;
    rd(ADDR_GLOBAL_FAULT_A, 8'hC0);
    wr(ADDR_FAULT_CLEAR, 8'h80);
    rd(ADDR_GLOBAL_FAULT_A, 8'h00);
    rd(ADDR_FAULT_CLEAR, 8'h00);
    $display("test event flags done");
    complete_run();
  end
endmodule : tb
`default_nettype wire

// ==== verilog/rsf_pkg.sv ====
// Shared constants for the ramp spread and fault register bank
`default_nettype none
package rsf_pkg;
  // Register offsets on the host control port
  localparam logic [7:0] ADDR_SPREAD_CONTROL  = 8'h6B;
  localparam logic [7:0] ADDR_SPREAD_RANGE    = 8'h6C;
  localparam logic [7:0] ADDR_RAMP_DIVISOR    = 8'h6D;
  localparam logic [7:0] ADDR_TRIANGLE_STEPS  = 8'h6E;
  localparam logic [7:0] ADDR_TRI_BOUND_AMP   = 8'h6F;
  localparam logic [7:0] ADDR_CHANNEL_FAULT   = 8'h70;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_A  = 8'h71;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_B  = 8'h72;
  localparam logic [7:0] ADDR_THERMAL_WARN    = 8'h73;
  localparam logic [7:0] ADDR_FAULT_CLEAR     = 8'h78;

  // Reset values
  localparam logic [7:0] RST_SPREAD_CONTROL   = 8'h00;
  localparam logic [7:0] RST_SPREAD_RANGE     = 8'h00;
  localparam logic [7:0] RST_RAMP_DIVISOR     = 8'h50;
  localparam logic [7:0] RST_TRIANGLE_STEPS   = 8'h11;
  localparam logic [7:0] RST_TRI_BOUND_AMP    = 8'h24;

  // Field positions in spread_control
  localparam int BIT_TRI_EN      = 0;
  localparam int BIT_RDM_EN      = 1;
  localparam int BIT_MANUAL      = 4;
  localparam int BIT_PRE_DIV     = 5;
  // Field positions in spread_range, triangle_steps, triangle_bound_amp
  localparam int RDM_RANGE_LSB   = 4;
  localparam int TRI_CTRL_LSB    = 0;
  localparam int FALL_STEP_LSB   = 4;
  localparam int RISE_STEP_LSB   = 0;
  localparam int PERIOD_LIM_LSB  = 0;
  localparam int AMP_LSB         = 5;
  // Fault flag positions
  localparam int BIT_LEFT_DC     = 3;
  localparam int BIT_RIGHT_DC    = 2;
  localparam int BIT_LEFT_OC     = 1;
  localparam int BIT_RIGHT_OC    = 0;
  localparam int BIT_OTP_CRC     = 7;
  localparam int BIT_COEF_WR     = 6;
  localparam int BIT_CLK_FAULT   = 2;
  localparam int BIT_PVDD_OV     = 1;
  localparam int BIT_PVDD_UV     = 0;
  localparam int BIT_THERM_SD    = 0;
  localparam int BIT_THERM_WARN  = 2;
  localparam int BIT_FAULT_CLEAR = 7;

  // Number of synchronised analog fault inputs
  localparam int NUM_ANALOG      = 9;
  // Ramp reference clock; manual ramp frequency is this over the divisor
  localparam int RAMP_REF_HZ     = 61440000;
  // Width of the ramp period counter
  localparam int PERIOD_W        = 10;
endpackage : rsf_pkg
`default_nettype wire

// ==== verilog/rsf_regs.sv ====
// Ramp spread configuration and fault flag register bank
`timescale 1ns/10ps
`default_nettype none
module rsf_regs (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       left_dc_det,
  input  wire logic       right_dc_det,
  input  wire logic       left_oc_det,
  input  wire logic       right_oc_det,
  input  wire logic       clock_fault_det,
  input  wire logic       supply_over_det,
  input  wire logic       supply_under_det,
  input  wire logic       thermal_shutdown_det,
  input  wire logic       thermal_warning_det,
  input  wire logic       otp_check_fail,
  input  wire logic       coef_write_fail,
  output logic            ramp_tick,
  output logic      [1:0] ramp_amplitude_setting,
  output logic            ramp_manual
);
  import rsf_pkg::*;

  logic [7:0]            spread_control;
  logic [7:0]            spread_range;
  logic [7:0]            ramp_divisor;
  logic [7:0]            triangle_steps;
  logic [7:0]            triangle_bound_amp;
  logic [3:0]            channel_fault_flags;
  logic [7:0]            global_fault_flags_a;
  logic                  thermal_shutdown_flag;
  logic                  thermal_warning_bit;
  logic [NUM_ANALOG-1:0] det_sync;
  logic [NUM_ANALOG-1:0] det_raw;
  logic [3:0]            chan_events;
  logic [7:0]            global_events;
  logic                  fault_clear;
  logic                  wr_ctrl;
  logic                  wr_range;
  logic                  wr_div;
  logic                  wr_steps;
  logic                  wr_bound;
  logic [7:0]            next_rdata;

  // Analog fault pins come from outside this clock domain
  assign det_raw = {thermal_warning_det, thermal_shutdown_det,
                    supply_under_det, supply_over_det, clock_fault_det,
                    right_oc_det, left_oc_det, right_dc_det, left_dc_det};

  rsf_sync #(
    .W (NUM_ANALOG)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (det_raw),
    .sync_out (det_sync)
  );

  // Write strobes, one per writable register
  always_comb begin
    wr_ctrl     = 1'b0;
    wr_range    = 1'b0;
    wr_div      = 1'b0;
    wr_steps    = 1'b0;
    wr_bound    = 1'b0;
    fault_clear = 1'b0;
    if (reg_wr) begin
      if (reg_addr == ADDR_SPREAD_CONTROL) wr_ctrl = 1'b1;
      else if (reg_addr == ADDR_SPREAD_RANGE) wr_range = 1'b1;
      else if (reg_addr == ADDR_RAMP_DIVISOR) wr_div = 1'b1;
      else if (reg_addr == ADDR_TRIANGLE_STEPS) wr_steps = 1'b1;
      else if (reg_addr == ADDR_TRI_BOUND_AMP) wr_bound = 1'b1;
      else if (reg_addr == ADDR_FAULT_CLEAR)
        fault_clear = reg_wdata[BIT_FAULT_CLEAR];
    end
  end

  // Spread configuration; reserved R/W bits are stored and read back
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spread_control     <= RST_SPREAD_CONTROL;
      spread_range       <= RST_SPREAD_RANGE;
      ramp_divisor       <= RST_RAMP_DIVISOR;
      triangle_steps     <= RST_TRIANGLE_STEPS;
      triangle_bound_amp <= RST_TRI_BOUND_AMP;
    end else begin
      if (wr_ctrl)  spread_control     <= reg_wdata;
      if (wr_range) spread_range       <= reg_wdata;
      if (wr_div)   ramp_divisor       <= reg_wdata;
      if (wr_steps) triangle_steps     <= reg_wdata;
      if (wr_bound) triangle_bound_amp <= reg_wdata;
    end
  end

  // Fault events in flag order
  assign chan_events = {det_sync[0], det_sync[1], det_sync[2], det_sync[3]};
  assign global_events = {otp_check_fail, coef_write_fail, 3'b000,
                          det_sync[4], det_sync[3+2], det_sync[6]};

  // Sticky fault flags; a new event outranks a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      channel_fault_flags   <= '0;
      global_fault_flags_a  <= '0;
      thermal_shutdown_flag <= 1'b0;
      thermal_warning_bit   <= 1'b0;
    end else begin
      channel_fault_flags <= (channel_fault_flags & {4{~fault_clear}})
                             | chan_events;
      global_fault_flags_a <= (global_fault_flags_a & {8{~fault_clear}})
                              | global_events;
      thermal_shutdown_flag <= (thermal_shutdown_flag & ~fault_clear)
                               | det_sync[7];
      thermal_warning_bit <= (thermal_warning_bit & ~fault_clear)
                             | det_sync[8];
    end
  end

  // Read decode; unmapped and write-only offsets read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_SPREAD_CONTROL) next_rdata = spread_control;
    else if (reg_addr == ADDR_SPREAD_RANGE) next_rdata = spread_range;
    else if (reg_addr == ADDR_RAMP_DIVISOR) next_rdata = ramp_divisor;
    else if (reg_addr == ADDR_TRIANGLE_STEPS) next_rdata = triangle_steps;
    else if (reg_addr == ADDR_TRI_BOUND_AMP) next_rdata = triangle_bound_amp;
    else if (reg_addr == ADDR_CHANNEL_FAULT)
      next_rdata = {4'h0, channel_fault_flags};
    else if (reg_addr == ADDR_GLOBAL_FAULT_A)
      next_rdata = global_fault_flags_a;
    else if (reg_addr == ADDR_GLOBAL_FAULT_B)
      next_rdata = {7'h00, thermal_shutdown_flag};
    else if (reg_addr == ADDR_THERMAL_WARN)
      next_rdata = {5'h00, thermal_warning_bit, 2'b00};
  end

  // Read data registered, valid one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  // Registered view of the ramp controls for the power stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ramp_amplitude_setting <= RST_TRI_BOUND_AMP[AMP_LSB+:2];
      ramp_manual            <= 1'b0;
    end else begin
      ramp_amplitude_setting <= triangle_bound_amp[AMP_LSB+:2];
      ramp_manual            <= spread_control[BIT_MANUAL];
    end
  end

  rsf_spread u_spread (
    .sys_clk               (sys_clk),
    .sys_rst               (sys_rst),
    .manual_mode           (spread_control[BIT_MANUAL]),
    .pre_div_sel           (spread_control[BIT_PRE_DIV]),
    .tri_enable            (spread_control[BIT_TRI_EN]),
    .random_spread_enable  (spread_control[BIT_RDM_EN]),
    .random_spread_range   (spread_range[RDM_RANGE_LSB+:3]),
    .triangle_ctrl         (spread_range[TRI_CTRL_LSB+:4]),
    .ramp_divisor_value    (ramp_divisor),
    .triangle_fall_step    (triangle_steps[FALL_STEP_LSB+:4]),
    .triangle_rise_step    (triangle_steps[RISE_STEP_LSB+:4]),
    .triangle_period_limit (triangle_bound_amp[PERIOD_LIM_LSB+:5]),
    .ramp_tick             (ramp_tick)
  );

  // Checks on register and flag behaviour
  sequence ctrl_write_s;
    reg_wr && reg_addr == ADDR_SPREAD_CONTROL;
  endsequence

  // Output copies lag their register by one more cycle
  sequence bound_write_s;
    reg_wr && reg_addr == ADDR_TRI_BOUND_AMP;
  endsequence

  manual_follows_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ctrl_write_s |=> ##1 ramp_manual == $past(reg_wdata[BIT_MANUAL], 2))
    else $error("manual mode output did not follow the write");

  amp_follows_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    bound_write_s |=> ##1
      ramp_amplitude_setting == $past(reg_wdata[AMP_LSB+:2], 2))
    else $error("amplitude output did not follow the write");

  divisor_reset_a: assert property (
    @(posedge sys_clk)
    sys_rst |=> ramp_divisor == RST_RAMP_DIVISOR
                && triangle_steps == RST_TRIANGLE_STEPS)
    else $error("spread registers wrong after reset");

  left_dc_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[0] |=> channel_fault_flags[BIT_LEFT_DC])
    else $error("left DC fault not flagged");

  right_dc_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[1] |=> channel_fault_flags[BIT_RIGHT_DC])
    else $error("right DC fault not flagged");

  left_oc_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[2] |=> channel_fault_flags[BIT_LEFT_OC])
    else $error("left overcurrent fault not flagged");

  right_oc_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[3] |=> channel_fault_flags[BIT_RIGHT_OC])
    else $error("right overcurrent fault not flagged");

  otp_error_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    otp_check_fail |=> global_fault_flags_a[BIT_OTP_CRC])
    else $error("OTP check error not flagged");

  coef_error_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    coef_write_fail |=> global_fault_flags_a[BIT_COEF_WR])
    else $error("coefficient write error not flagged");

  warn_read_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == ADDR_THERMAL_WARN && thermal_warning_bit)
    |=> reg_rvalid && reg_rdata == 8'h04)
    else $error("thermal warning read back wrong");

  warn_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[8] |=> thermal_warning_bit)
    else $error("thermal warning not flagged");

  shutdown_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[7] |=> thermal_shutdown_flag)
    else $error("thermal shutdown not flagged");

  shutdown_reserved_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == ADDR_GLOBAL_FAULT_B) |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved shutdown bits not zero");

  fault_clear_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (fault_clear && chan_events == 4'h0) |=> channel_fault_flags == 4'h0)
    else $error("fault clear left a channel flag set");

  clear_needs_bit_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == ADDR_FAULT_CLEAR && !reg_wdata[BIT_FAULT_CLEAR])
    |=> (channel_fault_flags & $past(channel_fault_flags))
        == $past(channel_fault_flags))
    else $error("clear write without the clear bit dropped a flag");

  ro_write_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == ADDR_GLOBAL_FAULT_A && global_events == 8'h00)
    |=> $stable(global_fault_flags_a))
    else $error("write changed a read-only flag");

  chan_reserved_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == ADDR_CHANNEL_FAULT) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved channel fault bits not zero");

  global_reserved_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == ADDR_GLOBAL_FAULT_A) |=> reg_rdata[5:3] == 3'h0)
    else $error("reserved global fault bits not zero");

  clock_fault_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[4] |=> global_fault_flags_a[BIT_CLK_FAULT])
    else $error("clock fault not flagged");

  supply_over_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[5] |=> global_fault_flags_a[BIT_PVDD_OV])
    else $error("supply overvoltage not flagged");

  supply_under_set_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    det_sync[6] |=> global_fault_flags_a[BIT_PVDD_UV])
    else $error("supply undervoltage not flagged");
endmodule : rsf_regs
`default_nettype wire

// ==== verilog/rsf_spread.sv ====
// Ramp spread-spectrum period generator
`timescale 1ns/10ps
`default_nettype none
module rsf_spread (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       manual_mode,
  input  wire logic       pre_div_sel,
  input  wire logic       tri_enable,
  input  wire logic       random_spread_enable,
  input  wire logic [2:0] random_spread_range,
  input  wire logic [3:0] triangle_ctrl,
  input  wire logic [7:0] ramp_divisor_value,
  input  wire logic [3:0] triangle_fall_step,
  input  wire logic [3:0] triangle_rise_step,
  input  wire logic [4:0] triangle_period_limit,
  output logic            ramp_tick
);
  import rsf_pkg::*;

  logic                       half_phase;
  logic                       src_en;
  logic [PERIOD_W-1:0]        count;
  logic signed [6:0]          tri_offset;
  logic                       tri_rising;
  logic [7:0]                 lfsr;
  logic [7:0]                 base_div;
  logic [4:0]                 limit;
  logic [3:0]                 up_step;
  logic [3:0]                 down_step;
  logic [6:0]                 rdm_offset;
  logic signed [PERIOD_W+1:0] period;

  // Auto mode uses the reset divisor and unit steps; manual uses registers
  assign base_div  = manual_mode ? ramp_divisor_value : RST_RAMP_DIVISOR;
  assign limit     = manual_mode ? triangle_period_limit
                                 : {1'b0, triangle_ctrl};
  assign up_step   = manual_mode ? triangle_rise_step : 4'h1;
  assign down_step = manual_mode ? triangle_fall_step : 4'h1;
  assign rdm_offset = lfsr[6:0] & 7'((8'h01 << random_spread_range) - 8'h01);

  // Effective period with spread applied, never under one source tick
  always_comb begin
    period = $signed({4'h0, base_div});
    if (tri_enable) period = period + 12'(tri_offset);
    if (random_spread_enable) begin
      period = period + $signed({5'h00, rdm_offset});
    end
    if (period < 12'sh001) period = 12'sh001;
  end

  // Source is the full clock or, in manual mode with pre_div_sel set, the clock halved
  assign src_en = !(manual_mode && pre_div_sel) || half_phase;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) half_phase <= 1'b0;
    else         half_phase <= ~half_phase;
  end

  // Period counter; the tick is the ramp-rate enable pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count     <= '0;
      ramp_tick <= 1'b0;
    end else begin
      ramp_tick <= 1'b0;
      if (src_en) begin
        if ({2'b00, count} >= period - 12'sh001) begin
          count     <= '0;
          ramp_tick <= 1'b1;
        end else begin
          count <= count + 10'h001;
        end
      end
    end
  end

  // Triangle walk between plus and minus the limit, once per ramp period
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tri_enable) begin
      tri_offset <= '0;
      tri_rising <= 1'b1;
    end else if (ramp_tick) begin
      if (tri_rising) begin
        if (tri_offset >= $signed({2'b00, limit})) tri_rising <= 1'b0;
        else tri_offset <= tri_offset + $signed({3'b000, up_step});
      end else begin
        if (tri_offset <= -$signed({2'b00, limit})) tri_rising <= 1'b1;
        else tri_offset <= tri_offset - $signed({3'b000, down_step});
      end
    end
  end

  // Pseudo-random source; nonzero seed so it cannot lock up
  always_ff @(posedge sys_clk) begin
    if (sys_rst) lfsr <= 8'h01;
    else if (ramp_tick) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // Only judged while the halved source stays selected across both cycles
  pre_div_half_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (manual_mode && pre_div_sel && src_en) ##1 (manual_mode && pre_div_sel)
    |-> !src_en)
    else $error("halved source enable ran two cycles in a row");
endmodule : rsf_spread
`default_nettype wire

// ==== verilog/rsf_sync.sv ====
// Three-stage synchroniser with agreement filter for fault pins
`timescale 1ns/10ps
`default_nettype none
module rsf_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // First stage feeds only the second, to settle metastability
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule : rsf_sync
`default_nettype wire
